// file: ulb_pkg.sv
// constants and types shared by the loopback / multidrop channel
package ulb_pkg;
    // register byte addresses
    localparam logic [11:0] ULB_MODE1_OFS = 12'h140;
    localparam logic [11:0] ULB_STATUS_OFS = 12'h144;
    localparam logic [11:0] ULB_CMD_OFS = 12'h148;
    localparam logic [11:0] ULB_BUF_OFS = 12'h14C;
    localparam logic [11:0] ULB_LOOP_OFS = 12'h160;
    localparam logic [11:0] ULB_VECTOR_OFS = 12'h170;
    // reset values
    localparam logic [7:0] ULB_MODE1_RST = 8'h00;
    localparam logic [7:0] ULB_VECTOR_RST = 8'h0F;
    localparam logic [1:0] ULB_LOOP_RST = 2'h0;
    // first mode register fields
    localparam int ULB_PM_HI = 4;
    localparam int ULB_PM_LO = 3;
    localparam int ULB_PT_BIT = 2;
    localparam logic [1:0] ULB_PM_NONE = 2'h2;
    localparam logic [1:0] ULB_PM_FORCE = 2'h1;
    localparam logic [1:0] ULB_PM_MULTIDROP = 2'h3;
    // command register bits
    localparam int ULB_CMD_RX_EN = 0;
    localparam int ULB_CMD_RX_DIS = 1;
    localparam int ULB_CMD_TX_EN = 2;
    localparam int ULB_CMD_TX_DIS = 3;
    localparam int ULB_CMD_ERR_RST = 4;
    // looping modes
    localparam logic [1:0] ULB_LOOP_NORMAL = 2'h0;
    localparam logic [1:0] ULB_LOOP_ECHO = 2'h1;
    localparam logic [1:0] ULB_LOOP_LOCAL = 2'h2;
    localparam logic [1:0] ULB_LOOP_REMOTE = 2'h3;
    // bit timing: 16 ticks per bit, half point at 8
    localparam logic [15:0] ULB_BAUD_DIV = 16'h000D;
    localparam logic [3:0] ULB_TICKS_LAST = 4'hF;
    localparam logic [3:0] ULB_TICKS_HALF = 4'h7;
    localparam logic [1:0] ULB_FIFO_DEPTH = 2'h3;

    typedef enum logic [4:0] {
        ULB_R_IDLE = 5'h01,
        ULB_R_START = 5'h02,
        ULB_R_DATA = 5'h04,
        ULB_R_TAG = 5'h08,
        ULB_R_STOP = 5'h10
    } ulb_rx_state_type;

    typedef enum logic [4:0] {
        ULB_T_IDLE = 5'h01,
        ULB_T_START = 5'h02,
        ULB_T_DATA = 5'h04,
        ULB_T_TAG = 5'h08,
        ULB_T_STOP = 5'h10
    } ulb_tx_state_type;

    // parity bit for the given data and mode settings
    function automatic logic ulb_par_bit(input logic [7:0] d, input logic [1:0] bc,
                                         input logic [1:0] pm, input logic pt);
        logic [7:0] m;
        m = d & (8'hFF >> (2'h3 - bc));
        if (pm == ULB_PM_FORCE) begin
            ulb_par_bit = pt;
        end else begin
            ulb_par_bit = (^m) ^ pt;
        end
    endfunction
endpackage

// file: ulb_tick_gen.sv
// oversampling tick divider for the serial channel
`timescale 1ns/100ps
module ulb_tick_gen
    import ulb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    output logic tick_r
);
    logic [15:0] cnt_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else if (cnt_r == ULB_BAUD_DIV) begin
            cnt_r <= 16'h0000;
            tick_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    a_tick_single: assert property (@(posedge clk_sys) disable iff (rst)
        tick_r |=> !tick_r) else $error("tick longer than one cycle");
endmodule // ulb_tick_gen

// file: ulb_channel.sv
// serial channel with looping modes, multidrop tagging and byte register bus
`timescale 1ns/100ps
module ulb_channel
    import ulb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    input wire logic iack_req,
    input wire logic autovec_en,
    output logic iack_ack,
    output logic [7:0] iack_vec
);
    ////////////////////////////////////////////////////////////////////////
    logic tick;
    logic rx_m_r, rx_s_r, rx_prev_r;
    logic [7:0] first_mode_reg, vector_number_reg;
    logic [1:0] loop_req_r, act_mode_r, pend_mode_r;
    logic pend_r, rx_en_r, tx_en_r;
    logic [3:0] hold_cnt_r;
    logic echo_hold_r;
    logic [31:0] prdata_r;
    logic txd_r, iack_ack_r;
    logic [7:0] iack_vec_r;

    ulb_tick_gen u_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick_r(tick)
    );

    // pin crosses in on two flops before anyone looks at it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_m_r <= 1'b1;
            rx_s_r <= 1'b1;
        end else begin
            rx_m_r <= rxd;
            rx_s_r <= rx_m_r;
        end
    end

    wire logic [1:0] pm = first_mode_reg[ULB_PM_HI:ULB_PM_LO];
    wire logic pt = first_mode_reg[ULB_PT_BIT];
    wire logic [1:0] bc = first_mode_reg[1:0];
    wire logic md = (pm == ULB_PM_MULTIDROP);
    wire logic has_tag = (pm != ULB_PM_NONE);
    wire logic m_echo = (act_mode_r == ULB_LOOP_ECHO);
    wire logic m_local = (act_mode_r == ULB_LOOP_LOCAL);
    wire logic m_remote = (act_mode_r == ULB_LOOP_REMOTE);
    wire logic echoing = m_echo || m_remote || echo_hold_r;
    wire logic wr_acc = psel && penable && pwrite && pstrb[0];
    wire logic rd_setup = psel && !penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////
    // receiver
    ulb_rx_state_type rx_st_r;
    logic [3:0] rx_tk_r;
    logic [2:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_tag_r, stop_half, push;
    logic tx_ser_r;
    // receiver listens to transmitter in local loopback
    wire logic rx_line = m_local ? tx_ser_r : rx_s_r;
    wire logic stop_bit = rx_line;
    wire logic rx_brk = (rx_sh_r == 8'h00) && !(has_tag && rx_tag_r) && !stop_bit;
    wire logic rx_pe = md ? rx_tag_r : (pm != ULB_PM_NONE) &&
        (rx_tag_r != ulb_par_bit(rx_sh_r, bc, pm, pt));
    assign stop_half = tick && (rx_st_r == ULB_R_STOP) && (rx_tk_r == ULB_TICKS_LAST);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_st_r <= ULB_R_IDLE;
            rx_tk_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_tag_r <= 1'b0;
            rx_prev_r <= 1'b1;
        end else if (tick) begin
            rx_prev_r <= rx_line;
            rx_tk_r <= rx_tk_r + 4'h1;
            case (rx_st_r)
                ULB_R_IDLE: begin
                    rx_tk_r <= 4'h0;
                    if (rx_prev_r && !rx_line) begin
                        rx_st_r <= ULB_R_START;
                        rx_sh_r <= 8'h00;
                        rx_bit_r <= 3'h0;
                    end
                end
                ULB_R_START: begin
                    if (rx_tk_r == ULB_TICKS_HALF) begin
                        rx_tk_r <= 4'h0;
                        rx_st_r <= rx_line ? ULB_R_IDLE : ULB_R_DATA;
                    end
                end
                ULB_R_DATA: begin
                    if (rx_tk_r == ULB_TICKS_LAST) begin
                        rx_sh_r[rx_bit_r] <= rx_line;
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == {1'b1, bc}) begin
                            rx_st_r <= has_tag ? ULB_R_TAG : ULB_R_STOP;
                        end
                    end
                end
                ULB_R_TAG: begin
                    if (rx_tk_r == ULB_TICKS_LAST) begin
                        rx_tag_r <= rx_line;
                        rx_st_r <= ULB_R_STOP;
                    end
                end
                ULB_R_STOP: begin
                    if (rx_tk_r == ULB_TICKS_LAST) begin
                        rx_st_r <= ULB_R_IDLE;
                    end
                end
                default: rx_st_r <= ULB_R_IDLE;
            endcase
        end
    end

    // disabled multidrop receiver keeps address characters only
    // enabled multidrop receiver keeps every character outside remote loopback
    assign push = stop_half && !m_remote && (rx_en_r || (md && rx_tag_r));

    ////////////////////////////////////////////////////////////////////////
    // receive holding stack, three entries of {break, framing, parity/tag, data}
    logic [10:0] fifo_r [0:2];
    logic [1:0] f_cnt_r;
    logic oe_r;
    wire logic pop = psel && penable && !pwrite && (paddr == ULB_BUF_OFS) && (f_cnt_r != 2'h0);
    wire logic f_full = (f_cnt_r == ULB_FIFO_DEPTH);
    wire logic do_push = push && !f_full;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            f_cnt_r <= 2'h0;
            for (int i = 0; i < 3; i++) begin
                fifo_r[i] <= 11'h000;
            end
        end else begin
            if (pop) begin
                fifo_r[0] <= fifo_r[1];
                fifo_r[1] <= fifo_r[2];
            end
            // tag stored in the parity-error slot
            if (do_push) begin
                fifo_r[pop ? f_cnt_r - 2'h1 : f_cnt_r] <= {rx_brk, !stop_bit, rx_pe, rx_sh_r};
            end
            f_cnt_r <= f_cnt_r + {1'b0, do_push} - {1'b0, pop};
        end
    end

    // overrun: a new character set against the clear still wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            oe_r <= 1'b0;
        end else if (push && f_full) begin
            oe_r <= 1'b1;
        end else if (wr_acc && paddr == ULB_CMD_OFS && pwdata[ULB_CMD_ERR_RST]) begin
            oe_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter from the CPU
    ulb_tx_state_type tx_st_r;
    logic [3:0] tx_tk_r;
    logic [2:0] tx_bit_r;
    logic [7:0] thr_r, tsh_r;
    logic thr_full_r;
    // CPU transmit path off in echo modes
    wire logic tx_run = tx_en_r && !m_echo && !m_remote;
    wire logic tx_load = wr_acc && (paddr == ULB_BUF_OFS) && tx_run && !thr_full_r;
    wire logic tx_take = tick && (tx_st_r == ULB_T_IDLE) && thr_full_r && tx_run;
    wire logic tx_rdy_flag = tx_run && !thr_full_r;
    wire logic tx_emp_flag = tx_rdy_flag && (tx_st_r == ULB_T_IDLE);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            thr_r <= 8'h00;
            thr_full_r <= 1'b0;
        end else if (tx_load) begin
            thr_r <= pwdata[7:0];
            thr_full_r <= 1'b1;
        end else if (tx_take) begin
            thr_full_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_st_r <= ULB_T_IDLE;
            tx_tk_r <= 4'h0;
            tx_bit_r <= 3'h0;
            tsh_r <= 8'h00;
            tx_ser_r <= 1'b1;
        end else if (tick) begin
            tx_tk_r <= tx_tk_r + 4'h1;
            case (tx_st_r)
                ULB_T_IDLE: begin
                    tx_tk_r <= 4'h0;
                    tx_ser_r <= 1'b1;
                    if (tx_take) begin
                        tsh_r <= thr_r;
                        tx_bit_r <= 3'h0;
                        tx_ser_r <= 1'b0;
                        tx_st_r <= ULB_T_START;
                    end
                end
                ULB_T_START, ULB_T_DATA: begin
                    if (tx_tk_r == ULB_TICKS_LAST) begin
                        tx_st_r <= ULB_T_DATA;
                        tx_ser_r <= tsh_r[tx_bit_r];
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_st_r == ULB_T_DATA && tx_bit_r == {1'b1, bc} + 3'h1) begin
                            // tag bit follows the data bits
                            // parity-type bit gives the tag value
                            tx_ser_r <= md ? pt : ulb_par_bit(tsh_r, bc, pm, pt);
                            tx_st_r <= has_tag ? ULB_T_TAG : ULB_T_STOP;
                            if (!has_tag) begin
                                tx_ser_r <= 1'b1;
                            end
                        end
                    end
                end
                ULB_T_TAG: begin
                    if (tx_tk_r == ULB_TICKS_LAST) begin
                        tx_ser_r <= 1'b1;
                        tx_st_r <= ULB_T_STOP;
                    end
                end
                ULB_T_STOP: begin
                    if (tx_tk_r == ULB_TICKS_LAST) begin
                        tx_st_r <= ULB_T_IDLE;
                    end
                end
                default: tx_st_r <= ULB_T_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // looping mode selection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            act_mode_r <= ULB_LOOP_RST;
            pend_mode_r <= ULB_LOOP_RST;
            pend_r <= 1'b0;
        end else if (wr_acc && paddr == ULB_LOOP_OFS) begin
            // echo modes defer their exit to the stop half point
            if ((m_echo || m_remote) && pwdata[1:0] != act_mode_r) begin
                pend_mode_r <= pwdata[1:0];
                pend_r <= 1'b1;
            end else begin
                act_mode_r <= pwdata[1:0];
                pend_r <= 1'b0;
            end
        end else if (pend_r && stop_half) begin
            act_mode_r <= pend_mode_r;
            pend_r <= 1'b0;
        end
    end

    // leaving echo mode (not remote), keep echoing through the second half of the stop bit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            echo_hold_r <= 1'b0;
            hold_cnt_r <= 4'h0;
        end else if (pend_r && stop_half && m_echo) begin
            echo_hold_r <= 1'b1;
            hold_cnt_r <= ULB_TICKS_HALF;
        end else if (echo_hold_r && tick) begin
            hold_cnt_r <= hold_cnt_r - 4'h1;
            echo_hold_r <= (hold_cnt_r != 4'h0);
        end
    end

    // bits go out untouched, parity and stop as received
    // a break passes straight through the echo path
    // local loopback holds the pin at mark, except while echo_hold_r is set
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txd_r <= 1'b1;
        end else begin
            txd_r <= echoing ? rx_s_r : (m_local ? 1'b1 : tx_ser_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register bus: byte lane 0 only, no wait states, never an error
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            first_mode_reg <= ULB_MODE1_RST;
            vector_number_reg <= ULB_VECTOR_RST;
            loop_req_r <= ULB_LOOP_RST;
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else if (wr_acc) begin
            case (paddr)
                ULB_MODE1_OFS: first_mode_reg <= pwdata[7:0];
                ULB_VECTOR_OFS: vector_number_reg <= pwdata[7:0];
                ULB_LOOP_OFS: loop_req_r <= pwdata[1:0];
                ULB_CMD_OFS: begin
                    if (pwdata[ULB_CMD_RX_EN]) rx_en_r <= 1'b1;
                    if (pwdata[ULB_CMD_RX_DIS]) rx_en_r <= 1'b0;
                    if (pwdata[ULB_CMD_TX_EN]) tx_en_r <= 1'b1;
                    if (pwdata[ULB_CMD_TX_DIS]) tx_en_r <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    // status: break, framing, parity/tag, overrun, tx empty, tx ready, full, ready
    wire logic [7:0] status_v = m_remote ? 8'h00 : {fifo_r[0][10:8] & {3{f_cnt_r != 2'h0}},
        oe_r, tx_emp_flag, tx_rdy_flag, f_full, f_cnt_r != 2'h0};

    // low lane only, reserved addresses read zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                ULB_MODE1_OFS: prdata_r <= {24'h000000, first_mode_reg};
                ULB_STATUS_OFS: prdata_r <= {24'h000000, status_v};
                ULB_BUF_OFS: prdata_r <= {24'h000000, m_remote ? 8'h00 : fifo_r[0][7:0]};
                ULB_LOOP_OFS: prdata_r <= {30'h00000000, loop_req_r};
                ULB_VECTOR_OFS: prdata_r <= {24'h000000, vector_number_reg};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // answer the acknowledge only when requesting and not autovectored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            iack_ack_r <= 1'b0;
            iack_vec_r <= 8'h00;
        end else begin
            iack_ack_r <= iack_req && !autovec_en && (f_cnt_r != 2'h0);
            iack_vec_r <= (iack_req && !autovec_en) ? vector_number_reg : 8'h00;
        end
    end

    assign prdata = prdata_r;
    always_ff @(posedge clk_sys) begin
        pready <= !rst;
        pslverr <= 1'b0;
    end
    assign txd = txd_r;
    assign iack_ack = iack_ack_r;
    assign iack_vec = iack_vec_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access phase not ready");
    a_no_error: assert property (psel && penable |-> !pslverr)
        else $error("bus error flagged");
    a_echo_flags: assert property (m_echo |-> !tx_emp_flag && !tx_rdy_flag)
        else $error("tx flags active in echo");
    a_echo_copy: assert property (m_echo ##1 m_echo |-> txd == $past(rx_s_r))
        else $error("echo output differs from input");
    a_local_mark: assert property (m_local && !echo_hold_r |=> txd)
        else $error("pin not at mark in local loopback");
    a_remote_quiet: assert property (m_remote |=> status_v == 8'h00 || !m_remote)
        else $error("status active in remote loopback");
    a_md_discard: assert property (do_push && !rx_en_r |-> md && rx_tag_r)
        else $error("data character kept while disabled");
    a_echo_exit: assert property (pend_r && stop_half |=> act_mode_r == $past(pend_mode_r))
        else $error("deferred mode not applied");
    a_mode_entry: assert property (wr_acc && paddr == ULB_LOOP_OFS && !m_echo && !m_remote
        |=> act_mode_r == $past(pwdata[1:0])) else $error("mode not entered");
    a_stop_tail: assert property (pend_r && stop_half && m_echo |=> echo_hold_r [*8])
        else $error("stop bit echo cut short");
    a_vector_out: assert property (iack_req && !autovec_en |=> iack_vec == vector_number_reg)
        else $error("vector not supplied");

    c_echo_mode: cover property (m_echo ##1 stop_half);
    c_md_address: cover property (do_push && md && rx_tag_r);
    c_local_push: cover property (m_local && do_push);
    c_iack_win: cover property (iack_ack);
endmodule // ulb_channel

// file: ulb_remote_station.sv
// remote serial station that drives the channel's receive pin
`timescale 1ns/100ps
module ulb_remote_station
    import ulb_pkg::*;
#(parameter int BIT_CLKS = 224)
(
    input wire logic clk_sys,
    output logic rxd
);
    initial rxd = 1'h1;
    ////////////////////////////////////////////////////////////////
    // multidrop frame
    // start, data lsb first, tag, one stop; the stop bit leaves line at mark
    task automatic send(input logic [7:0] d, input logic tag);
        logic [10:0] f;
        f = {1'h1, tag, d, 1'h0};
        @(posedge clk_sys);
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BIT_CLKS) @(posedge clk_sys);
        end
    endtask
endmodule // ulb_remote_station

// file: testbench.sv
// self-checking bench for the loopback and multidrop channel
`timescale 1ns/100ps
module testbench
    import ulb_pkg::*;
;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, rxd, txd, iack_ack;
    logic iack_req = 1'h0;
    logic autovec_en = 1'h0;
    logic [7:0] iack_vec;
    logic [2:0] hist = 3'h7;
    logic echo_on = 1'h0;
    logic mark_on = 1'h0;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    ulb_channel u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .iack_req(iack_req),
        .autovec_en(autovec_en), .iack_ack(iack_ack), .iack_vec(iack_vec));
    ulb_remote_station u_rs (.clk_sys(clk_sys), .rxd(rxd));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, s, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // echo path is 3 clocks (2 sync + output flop); timeout cuts a hang
    always @(posedge clk_sys) begin
        hist <= {hist[1:0], rxd};
        cycles <= cycles + 1;
        if (echo_on) chk(txd, hist[2], "echo");
        if (mark_on) chk(txd, 1'h1, "mark");
        if (cycles == 40000) begin
            num_errors++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1);
        q = prdata[7:0];
        chk(prdata[31:8], 24'h0, "lanes");
        chk(n, 1, "waits");
        chk(pslverr, 1'h0, "slverr");
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        apb(1'h1, a, d, q);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e,
                       input string s);
        logic [7:0] q;
        apb(1'h0, a, 8'h00, q);
        chk(q & m, e, s);
    endtask
    task automatic wait_rx();
        logic [7:0] q;
        q = 8'h00;
        for (int i = 0; i < 1200 && q[0] !== 1'h1; i++) apb(1'h0, ULB_STATUS_OFS, 8'h00, q);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdc(ULB_VECTOR_OFS, 8'hFF, ULB_VECTOR_RST, "vec rst");
        rdc(ULB_MODE1_OFS, 8'hFF, ULB_MODE1_RST, "mode rst");
        wr(12'h150, 8'hA5);
        rdc(12'h150, 8'hFF, 8'h00, "reserved");
        wr(ULB_VECTOR_OFS, 8'h5A);
        rdc(ULB_VECTOR_OFS, 8'hFF, 8'h5A, "vec");
        $display("test regs done");
    endtask
    task automatic t_multidrop();
        wr(ULB_MODE1_OFS, 8'h1B);
        wr(ULB_CMD_OFS, 8'h0A);
        u_rs.send(8'h11, 1'h0);
        rdc(ULB_STATUS_OFS, 8'h01, 8'h00, "data dropped");
        u_rs.send(8'hA5, 1'h1);
        rdc(ULB_STATUS_OFS, 8'hE1, 8'h21, "addr kept");
        rdc(ULB_BUF_OFS, 8'hFF, 8'hA5, "addr data");
        wr(ULB_CMD_OFS, 8'h01);
        u_rs.send(8'h3C, 1'h0);
        rdc(ULB_STATUS_OFS, 8'hE1, 8'h01, "data kept");
        rdc(ULB_BUF_OFS, 8'hFF, 8'h3C, "data");
        $display("test multidrop done");
    endtask
    // receive pin is ignored here, so the station's frame must not land
    task automatic t_local();
        wr(ULB_MODE1_OFS, 8'h1F);
        wr(ULB_LOOP_OFS, {6'h0, ULB_LOOP_LOCAL});
        wr(ULB_CMD_OFS, 8'h06);
        mark_on <= 1'h1;
        wr(ULB_BUF_OFS, 8'hC3);
        fork
            u_rs.send(8'h77, 1'h1);
            wait_rx();
        join
        mark_on <= 1'h0;
        rdc(ULB_STATUS_OFS, 8'hE1, 8'h21, "looped tag");
        $display("test local done");
    endtask
    task automatic t_iack();
        iack_req <= 1'h1;
        repeat (2) @(posedge clk_sys);
        chk({iack_ack, iack_vec}, 9'h15A, "vector");
        autovec_en <= 1'h1;
        repeat (2) @(posedge clk_sys);
        chk({iack_ack, iack_vec}, 9'h000, "autovec");
        iack_req <= 1'h0;
        autovec_en <= 1'h0;
        rdc(ULB_BUF_OFS, 8'hFF, 8'hC3, "looped");
        $display("test iack done");
    endtask
    task automatic t_echo();
        wr(ULB_CMD_OFS, 8'h01);
        wr(ULB_LOOP_OFS, {6'h0, ULB_LOOP_REMOTE});
        echo_on <= 1'h1;
        u_rs.send(8'h96, 1'h1);
        rdc(ULB_STATUS_OFS, 8'hFF, 8'h00, "hidden");
        rdc(ULB_BUF_OFS, 8'hFF, 8'h00, "hidden buf");
        wr(ULB_LOOP_OFS, {6'h0, ULB_LOOP_ECHO});
        wr(ULB_CMD_OFS, 8'h09);
        // remote holds until this frame's stop half point, so it is never stacked
        u_rs.send(8'h5C, 1'h1);
        rdc(ULB_STATUS_OFS, 8'h0D, 8'h00, "echo flags");
        // leaving echo: this frame is stacked and its stop bit tail still echoed
        wr(ULB_LOOP_OFS, {6'h0, ULB_LOOP_NORMAL});
        u_rs.send(8'hE7, 1'h1);
        echo_on <= 1'h0;
        rdc(ULB_STATUS_OFS, 8'h01, 8'h01, "echo status");
        rdc(ULB_BUF_OFS, 8'hFF, 8'hE7, "echo data");
        $display("test echo done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (2) @(posedge clk_sys);
        t_regs();
        t_multidrop();
        t_local();
        t_iack();
        t_echo();
        end_sim();
    end
endmodule // testbench
